/* mdc_clk_div.v */
`timescale 1ns/1ps
`default_nettype none

// Pulse enables for spindle, supply and converter rates
module mdc_clk_div
(
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Selects
    input wire prescale,
    input wire [1:0] adc_sel,
    // Enables
    output reg spindle_en,
    output reg supply_en,
    output reg adc_en
);

    reg [2:0] cnt_q;

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= 3'h0;
        else
            cnt_q <= cnt_q + 3'h1;
    end

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            spindle_en <= 1'b0;
            supply_en <= 1'b0;
            adc_en <= 1'b0;
        end
        else
        begin
            spindle_en <= prescale ? 1'b1 : (cnt_q[0] == 1'b1);
            supply_en <= prescale ? (cnt_q[1:0] == 2'h3) : (cnt_q == 3'h7);
            case (adc_sel)
                2'h0: adc_en <= 1'b0;
                2'h1: adc_en <= (cnt_q[1:0] == 2'h3);
                2'h2: adc_en <= cnt_q[0];
                default: adc_en <= 1'b1;
            endcase
        end
    end

endmodule
`default_nettype wire

/* mdc_consts.vh */
`ifndef MDC_CONSTS_VH
`define MDC_CONSTS_VH

// ==========================================
// Register offsets
`define MDC_OFF_BRAKE_SHOCK 4'h2
`define MDC_OFF_STATE_CTRL 4'h3
`define MDC_OFF_SPIN_CFG 4'h4
`define MDC_OFF_PROT_CTRL 4'h5
`define MDC_OFF_CLK_WIN 4'h6
`define MDC_OFF_PHASE_CTRL 4'h7
`define MDC_OFF_GAIN 4'h8

// ==========================================
// Reset values
`define MDC_RST_BYTE 8'h00
`define MDC_RST_STATE_CTRL 8'h10

// ==========================================
// Field positions
`define MDC_BRAKE_LSB 4
`define MDC_SHK_TH_BIT 6
`define MDC_SHK_TYPE_BIT 7
`define MDC_ACT_LSB 4
`define MDC_CAL_BIT 7
`define MDC_LATCH_BIT 0
`define MDC_VNEG_BIT 1
`define MDC_TSD_BIT 2
`define MDC_MASK_LSB 3
`define MDC_INV_BIT 7
`define MDC_PRESCALE_BIT 0
`define MDC_ADC_LSB 1
`define MDC_WIN_LSB 3
`define MDC_COMP_BIT 5
`define MDC_STEP_BIT 6
`define MDC_LOAD_BIT 7

// ==========================================
// Timing
`define MDC_CLK_MHZ 200
`define MDC_BRAKE_BASE_US 300
`define MDC_BRAKE_STEP_US 100
`define MDC_BLANK_STEP_US 2
`define MDC_SAMPLES 48

`endif

/* mdc_ctrl_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module mdc_ctrl_monitor (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Register port
    input wire wr_en,
    input wire rd_en,
    input wire [3:0] addr,
    input wire [7:0] wr_data,
    input wire [7:0] rd_data,
    // Observed
    input wire brake_start,
    input wire sample_tick,
    input wire brake_off_active,
    input wire [8:0] spindle_state_hot,
    input wire [2:0] actuator_state_sel,
    input wire [5:0] sample_pos,
    input wire [7:0] speed_loop_gain,
    input wire spindle_clk_en,
    input wire converter_clk_en
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // Shadow of written step, load and clock bits
    logic [7:0] ph_q;
    logic [2:0] ck_q;
    wire wr7 = wr_en && addr == 4'h7;
    wire step_up = wr7 && wr_data[6] && !ph_q[6];
    wire load_up = wr7 && wr_data[7] && !ph_q[7];
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ph_q <= 8'h00;
            ck_q <= 3'h0;
        end
        else
        begin
            if (wr7)
                ph_q <= wr_data;
            if (wr_en && addr == 4'h6)
                ck_q <= wr_data[2:0];
        end
    end
    // ==========================================
    // Assertions
    gain_write_a: assert property (wr_en && addr == 4'h8 |=> ##1
        speed_loop_gain == $past(wr_data, 2)) else $error("gain field wrong");
    act_keep_a: assert property (wr_en && addr == 4'h3 && wr_data[6:5] == 2'b11
        |=> ##1 $stable(actuator_state_sel)) else $error("actuator state moved");
    act_set_a: assert property (wr_en && addr == 4'h3 && wr_data[6:4] < 3'h6
        |=> ##1 actuator_state_sel == $past(wr_data[6:4], 2)) else $error("actuator wrong");
    spin_hot_a: assert property (wr_en && addr == 4'h3 |=> ##1 spindle_state_hot ==
        ($past(wr_data[3:0], 2) > 4'h8 ? 9'h000 : 9'h001 << $past(wr_data[3:0], 2)))
        else $error("spindle state wrong");
    // Position moves on the write edge itself; a later tick must not be blamed
    step_adv_a: assert property (step_up && !load_up && !sample_tick |=>
        sample_pos == ($past(sample_pos) == 6'd47 ? 6'd0 : $past(sample_pos) + 6'd1))
        else $error("step did not advance");
    load_pos_a: assert property (load_up |=>
        sample_pos == {1'b0, $past(wr_data[4:0])}) else $error("load wrong");
    brake_start_a: assert property (brake_start |-> ##2 brake_off_active)
        else $error("brake off time not started");
    unmapped_rd_a: assert property (rd_en && (addr < 4'h2 || addr > 4'h8) |=>
        rd_data == 8'h00) else $error("unmapped read not zero");
    // Enable trails the select by two stages, so three settled samples are needed
    spin_half_a: assert property (!ck_q[0] && !$past(ck_q[0]) && !$past(ck_q[0], 2)
        && spindle_clk_en
        |=> !spindle_clk_en) else $error("spindle clock not halved");
    adc_sleep_a: assert property (ck_q[2:1] == 2'b00 && $past(ck_q[2:1], 2) == 2'b00
        && $past(ck_q[2:1]) == 2'b00 |-> !converter_clk_en) else $error("converter awake");
    cover property (load_up);
    cover property (step_up && sample_pos == 6'd47);
    cover property (brake_start ##2 brake_off_active);
endmodule
bind mdc_ctrl_regs mdc_ctrl_monitor i_mdc_ctrl_monitor (.*);
`default_nettype wire

/* mdc_ctrl_regs.v */
`timescale 1ns/1ps
`default_nettype none
`include "mdc_consts.vh"

module mdc_ctrl_regs
#(
    parameter BRAKE_W = 17
)
(
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Register port
    input wire wr_en,
    input wire rd_en,
    input wire [3:0] addr,
    input wire [7:0] wr_data,
    output reg [7:0] rd_data,
    // Brake and shock
    input wire brake_start,
    input wire pwm_rise,
    input wire shock_raw,
    output reg brake_off_active,
    output reg shock_sensor_type,
    output reg shock_threshold_sel,
    output reg shock_flag,
    // Spindle state one-hot
    output reg [8:0] spindle_state_hot,
    // Actuator
    output reg [2:0] actuator_state_sel,
    output reg backemf_offset_cal,
    // Spindle drive
    output reg current_sense_blank,
    output reg [2:0] current_limit_sel,
    output reg [2:0] slew_rate_sel,
    // Protection
    output reg neg_reg_en,
    output reg thermal_shutdown_en,
    output reg serial_clock_invert,
    // Clocks
    output reg spindle_clk_en,
    output reg supply_comp_converter_en,
    output reg converter_clk_en,
    // Zero crossing and phase
    input wire sample_tick,
    output reg [3:0] zero_crossing_mask,
    output reg [4:0] zero_crossing_window,
    output reg [4:0] torque_phase_offset,
    output reg supply_comp_en,
    output reg [5:0] sample_pos,
    output reg [7:0] speed_loop_gain
);

    // ==========================================
    // Register storage
    reg [7:0] bs_q;
    reg [7:0] sc_q;
    reg [7:0] sd_q;
    reg [7:0] pc_q;
    reg [7:0] cw_q;
    reg [7:0] ph_q;
    reg [7:0] kv_q;
    reg [2:0] act_q;
    reg [1:0] unlatch_q;
    reg shock_hold_q;
    reg [5:0] pos_d;

    wire [2:0] act_wr = wr_data[`MDC_ACT_LSB+2:`MDC_ACT_LSB];
    wire wr_sc = wr_en && (addr == `MDC_OFF_STATE_CTRL);
    wire wr_ph = wr_en && (addr == `MDC_OFF_PHASE_CTRL);
    wire wr_pc = wr_en && (addr == `MDC_OFF_PROT_CTRL);
    // Edge seen against the stored bit, not a free-running sample
    wire step_rise = wr_ph && wr_data[`MDC_STEP_BIT] && !ph_q[`MDC_STEP_BIT];
    wire load_rise = wr_ph && wr_data[`MDC_LOAD_BIT] && !ph_q[`MDC_LOAD_BIT];

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bs_q <= `MDC_RST_BYTE;
            sc_q <= `MDC_RST_STATE_CTRL;
            sd_q <= `MDC_RST_BYTE;
            pc_q <= `MDC_RST_BYTE;
            cw_q <= `MDC_RST_BYTE;
            ph_q <= `MDC_RST_BYTE;
            kv_q <= `MDC_RST_BYTE;
            act_q <= 3'h1;
        end
        else if (wr_en)
        begin
            case (addr)
                `MDC_OFF_BRAKE_SHOCK: bs_q <= wr_data;
                `MDC_OFF_STATE_CTRL: sc_q <= wr_data;
                `MDC_OFF_SPIN_CFG: sd_q <= wr_data;
                `MDC_OFF_PROT_CTRL: pc_q <= wr_data;
                `MDC_OFF_CLK_WIN: cw_q <= wr_data;
                `MDC_OFF_PHASE_CTRL: ph_q <= wr_data;
                `MDC_OFF_GAIN: kv_q <= wr_data;
                default: bs_q <= bs_q;
            endcase
            if (wr_sc && act_wr <= 3'h5)
                act_q <= act_wr;
        end
    end

    // ==========================================
    // Read back
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            rd_data <= 8'h00;
        else if (rd_en)
        begin
            case (addr)
                `MDC_OFF_BRAKE_SHOCK: rd_data <= bs_q;
                `MDC_OFF_STATE_CTRL: rd_data <= sc_q;
                `MDC_OFF_SPIN_CFG: rd_data <= sd_q;
                `MDC_OFF_PROT_CTRL: rd_data <= pc_q;
                `MDC_OFF_CLK_WIN: rd_data <= cw_q;
                `MDC_OFF_PHASE_CTRL: rd_data <= ph_q;
                `MDC_OFF_GAIN: rd_data <= kv_q;
                default: rd_data <= 8'h00;
            endcase
        end
    end

    // ==========================================
    // Shock latch
    // Clear needs the full one-zero-one sequence; a lone zero does not clear
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            unlatch_q <= 2'h0;
            shock_hold_q <= 1'b0;
            shock_flag <= 1'b0;
        end
        else
        begin
            if (wr_pc)
            begin
                if (pc_q[`MDC_LATCH_BIT] && !wr_data[`MDC_LATCH_BIT])
                    unlatch_q <= 2'h1;
                else if (unlatch_q == 2'h1 && wr_data[`MDC_LATCH_BIT])
                    unlatch_q <= 2'h2;
                else
                    unlatch_q <= unlatch_q;
            end
            else if (unlatch_q == 2'h2)
                unlatch_q <= 2'h0;
            // New shock wins over the clear
            if (shock_raw)
                shock_hold_q <= 1'b1;
            else if (unlatch_q == 2'h2)
                shock_hold_q <= 1'b0;
            shock_flag <= pc_q[`MDC_LATCH_BIT] ? (shock_hold_q | shock_raw) : shock_raw;
        end
    end

    // ==========================================
    // Sample position
    always @*
    begin
        pos_d = sample_pos;
        if (load_rise)
            pos_d = {1'b0, ph_q[4:0] & 5'h00} | {1'b0, wr_data[4:0]};
        else if (step_rise || sample_tick)
            pos_d = (sample_pos == 6'd47) ? 6'h00 : sample_pos + 6'h01;
    end

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            sample_pos <= 6'h00;
        else
            sample_pos <= pos_d;
    end

    // ==========================================
    // Field outputs
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shock_sensor_type <= 1'b0;
            shock_threshold_sel <= 1'b0;
            spindle_state_hot <= 9'h001;
            actuator_state_sel <= 3'h1;
            backemf_offset_cal <= 1'b0;
            current_limit_sel <= 3'h0;
            slew_rate_sel <= 3'h0;
            neg_reg_en <= 1'b0;
            thermal_shutdown_en <= 1'b0;
            serial_clock_invert <= 1'b0;
            zero_crossing_mask <= 4'h0;
            zero_crossing_window <= 5'h00;
            torque_phase_offset <= 5'h00;
            supply_comp_en <= 1'b0;
            speed_loop_gain <= 8'h00;
        end
        else
        begin
            shock_sensor_type <= bs_q[`MDC_SHK_TYPE_BIT];
            shock_threshold_sel <= bs_q[`MDC_SHK_TH_BIT];
            // Codes above 1000 give no state
            spindle_state_hot <= (sc_q[3:0] <= 4'h8) ? (9'h001 << sc_q[3:0]) : 9'h000;
            actuator_state_sel <= act_q;
            backemf_offset_cal <= sc_q[`MDC_CAL_BIT];
            // Code 110 left as written; no threshold defined for it
            current_limit_sel <= sd_q[4:2];
            slew_rate_sel <= sd_q[7:5];
            neg_reg_en <= pc_q[`MDC_VNEG_BIT];
            thermal_shutdown_en <= pc_q[`MDC_TSD_BIT];
            serial_clock_invert <= pc_q[`MDC_INV_BIT];
            zero_crossing_mask <= pc_q[`MDC_MASK_LSB+3:`MDC_MASK_LSB];
            zero_crossing_window <= cw_q[`MDC_WIN_LSB+4:`MDC_WIN_LSB];
            torque_phase_offset <= ph_q[4:0];
            supply_comp_en <= ph_q[`MDC_COMP_BIT];
            speed_loop_gain <= kv_q;
        end
    end

    // ==========================================
    // Timers and clock enables
    localparam [BRAKE_W-1:0] BRAKE_BASE = `MDC_BRAKE_BASE_US * `MDC_CLK_MHZ;
    localparam [BRAKE_W-1:0] BRAKE_STEP = `MDC_BRAKE_STEP_US * `MDC_CLK_MHZ;
    localparam [10:0] BLANK_STEP = `MDC_BLANK_STEP_US * `MDC_CLK_MHZ;

    wire [BRAKE_W-1:0] brake_len = BRAKE_BASE +
        BRAKE_STEP * {{(BRAKE_W-2){1'b0}}, bs_q[`MDC_BRAKE_LSB+1:`MDC_BRAKE_LSB]};
    wire [10:0] blank_len = BLANK_STEP * {9'h000, sd_q[1:0]} + BLANK_STEP;
    wire brake_busy;
    wire blank_busy;
    wire sp_en;
    wire sup_en;
    wire adc_en;

    mdc_timer #(.W(BRAKE_W)) u_brake
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(brake_start),
        .len(brake_len),
        .busy(brake_busy)
    );

    mdc_timer #(.W(11)) u_blank
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(pwm_rise),
        .len(blank_len),
        .busy(blank_busy)
    );

    mdc_clk_div u_div
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .prescale(cw_q[`MDC_PRESCALE_BIT]),
        .adc_sel(cw_q[`MDC_ADC_LSB+1:`MDC_ADC_LSB]),
        .spindle_en(sp_en),
        .supply_en(sup_en),
        .adc_en(adc_en)
    );

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            brake_off_active <= 1'b0;
            current_sense_blank <= 1'b0;
            spindle_clk_en <= 1'b0;
            supply_comp_converter_en <= 1'b0;
            converter_clk_en <= 1'b0;
        end
        else
        begin
            brake_off_active <= brake_busy;
            current_sense_blank <= blank_busy;
            spindle_clk_en <= sp_en;
            supply_comp_converter_en <= sup_en;
            converter_clk_en <= adc_en;
        end
    end

endmodule
`default_nettype wire

/* mdc_ctrl_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
module mdc_ctrl_regs_test;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic brake_start = 1'b0;
    logic pwm_rise = 1'b0;
    logic shock_raw = 1'b0;
    logic sample_tick = 1'b0;
    wire wr_en, rd_en;
    wire [3:0] addr, zero_crossing_mask;
    wire [7:0] wr_data, rd_data, speed_loop_gain;
    wire [8:0] spindle_state_hot;
    wire [5:0] sample_pos;
    wire [4:0] zero_crossing_window, torque_phase_offset;
    wire [2:0] actuator_state_sel, current_limit_sel, slew_rate_sel;
    wire brake_off_active, shock_sensor_type, shock_threshold_sel, shock_flag;
    wire backemf_offset_cal, current_sense_blank, neg_reg_en, thermal_shutdown_en;
    wire serial_clock_invert, spindle_clk_en, supply_comp_converter_en;
    wire converter_clk_en, supply_comp_en;
    int error_cnt = 0;
    int check_count = 0;
    logic [31:0] seed = 32'h8051;
    logic [7:0] mem [0:15];
    // Register keeps raw bits; the actuator state keeps its own copy
    logic [2:0] act_exp = 3'h1;
    mdc_ctrl_regs i_mdc_ctrl_regs (.*);
    mdc_host_model i_mdc_host_model (.*);
    initial
    begin
        forever #2.5 core_clk = ~core_clk;
    end
    // ==========================================
    // Helpers
    task automatic results;
        if (error_cnt == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s exp %h seen %h", n, exp, seen);
        end
    endtask
    function automatic logic [31:0] rnd();
        seed = seed[0] ? (seed >> 1) ^ 32'h80200003 : seed >> 1;
        return seed;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic mw(input logic [3:0] a, input logic [7:0] d);
        if (a == 4'h3 && d[6:5] != 2'b11)
            act_exp = d[6:4];
        mem[a] = d;
        i_mdc_host_model.wr(a, d);
    endtask
    task automatic rdchk(input logic [3:0] a);
        logic [7:0] v;
        i_mdc_host_model.rd(a, v);
        chk("rd_data", v, mem[a]);
    endtask
    // Pulse on one input, then width of the resulting window
    task automatic width(input bit blank, input int exp);
        int w;
        int i;
        w = 0;
        if (blank)
            pwm_rise = 1'b1;
        else
            brake_start = 1'b1;
        cyc(1);
        pwm_rise = 1'b0;
        brake_start = 1'b0;
        for (i = 0; i < 70000 && (blank ? current_sense_blank : brake_off_active); i++)
            cyc(1);
        for (i = 0; i < 70000 && (blank ? current_sense_blank : brake_off_active) !== 1'b1; i++)
            cyc(1);
        while (w < 70000 && (blank ? current_sense_blank : brake_off_active) === 1'b1)
        begin
            w++;
            cyc(1);
        end
        chk("window", w, exp);
    endtask
    // ==========================================
    // Sequence
    initial
    begin
        int k;
        int ns;
        int nf;
        int na;
        for (k = 0; k < 16; k++)
            mem[k] = 8'h00;
        mem[3] = 8'h10;
        cyc(3);
        rst_n = 1'b1;
        chk("act", actuator_state_sel, 3'h1);
        chk("hot", spindle_state_hot, 9'h001);
        for (k = 0; k < 16; k++)
            rdchk(k[3:0]);
        mw(7, 8'h9f);
        cyc(2);
        chk("pos", sample_pos, 6'd31);
        sample_tick = 1'b1;
        cyc(16);
        sample_tick = 1'b0;
        cyc(2);
        chk("pos", sample_pos, 6'd47);
        mw(7, 8'h40);
        cyc(2);
        chk("pos", sample_pos, 6'd0);
        mw(7, 8'h40);
        cyc(2);
        chk("pos", sample_pos, 6'd0);
        for (k = 0; k < 16; k++)
        begin
            mw(3, {k[3], k[2:0], k[3:0]});
            cyc(2);
            chk("act", actuator_state_sel, act_exp);
            chk("cal", backemf_offset_cal, k[3]);
            chk("hot", spindle_state_hot, k < 9 ? 9'h001 << k : 9'h000);
        end
        for (k = 0; k < 24; k++)
            mw(4'h2 + rnd() % 7, rnd());
        cyc(2);
        chk("gain", speed_loop_gain, mem[8]);
        chk("shock", {shock_sensor_type, shock_threshold_sel}, mem[2][7:6]);
        chk("spin", {slew_rate_sel, current_limit_sel}, mem[4][7:2]);
        chk("prot", {serial_clock_invert, zero_crossing_mask, thermal_shutdown_en,
            neg_reg_en}, mem[5][7:1]);
        chk("win", zero_crossing_window, mem[6][7:3]);
        chk("phase", {supply_comp_en, torque_phase_offset}, mem[7][5:0]);
        for (k = 0; k < 16; k++)
            rdchk(k[3:0]);
        for (k = 0; k < 8; k++)
        begin
            mw(6, k[7:0]);
            cyc(8);
            ns = 0;
            nf = 0;
            na = 0;
            repeat (40)
            begin
                cyc(1);
                ns += spindle_clk_en;
                nf += supply_comp_converter_en;
                na += converter_clk_en;
            end
            chk("spin_clk", ns, k[0] ? 40 : 20);
            chk("supply_clk", nf, k[0] ? 10 : 5);
            chk("adc_clk", na, k[2:1] == 0 ? 0 : 40 >> (3 - k[2:1]));
        end
        mw(5, 8'h01);
        shock_raw = 1'b1;
        cyc(1);
        shock_raw = 1'b0;
        cyc(3);
        chk("flag", shock_flag, 1'b1);
        mw(5, 8'h00);
        mw(5, 8'h01);
        cyc(3);
        chk("flag", shock_flag, 1'b0);
        mw(5, 8'h00);
        shock_raw = 1'b1;
        cyc(3);
        chk("flag", shock_flag, 1'b1);
        shock_raw = 1'b0;
        cyc(3);
        chk("flag", shock_flag, 1'b0);
        mw(4, 8'h03);
        cyc(2);
        width(1'b1, 1600);
        mw(4, 8'h00);
        cyc(2);
        width(1'b1, 400);
        mw(2, 8'h00);
        cyc(2);
        width(1'b0, 60000);
        results();
    end
    initial
    begin
        #450us;
        error_cnt++;
        results();
    end
endmodule
`default_nettype wire

/* mdc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mdc_host_model (
    // Clock
    input wire logic core_clk,
    // Register port
    output logic wr_en,
    output logic rd_en,
    output logic [3:0] addr,
    output logic [7:0] wr_data,
    input wire logic [7:0] rd_data
);
    initial
    begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 4'h0;
        wr_data = 8'h00;
    end
    // Released data is inverted so a stale value never passes
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        addr = a;
        wr_data = d;
        wr_en = 1'b1;
        @(posedge core_clk);
        #1;
        wr_en = 1'b0;
        wr_data = ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        #1;
        addr = a;
        rd_en = 1'b1;
        @(posedge core_clk);
        #1;
        rd_en = 1'b0;
        d = rd_data;
    endtask
endmodule
`default_nettype wire

/* mdc_timer.v */
`timescale 1ns/1ps
`default_nettype none

// One-shot window: high for len cycles after each start pulse
module mdc_timer
#(
    parameter W = 17
)
(
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Control
    input wire start,
    input wire [W-1:0] len,
    // Status
    output reg busy
);

    reg [W-1:0] cnt_q;

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= {W{1'b0}};
            busy <= 1'b0;
        end
        else if (start)
        begin
            cnt_q <= len;
            busy <= (len != {W{1'b0}});
        end
        else if (cnt_q != {W{1'b0}})
        begin
            cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
            busy <= (cnt_q != {{(W-1){1'b0}}, 1'b1});
        end
        else
            busy <= 1'b0;
    end

endmodule
`default_nettype wire
